//--- hdl/hlot_timer.sv
// hardware-limit one-shot 8-bit timer with AXI4-Lite register access
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Overview of operation
// - Edge one-shot modes wait, with run set, for the chosen rising, falling or either edge.
// - If software stops an edge one-shot, a fresh edge after run is set again resumes it.
// - In edge one-shot, the start edge raises the PWM drive, the width match drops it.
// - In edge limit one-shot, the first edge starts counting and later edges reset the count.
// - After each later reset edge the counter restarts by itself two timer clocks on.
// - In edge limit one-shot, a period match resets the count and clears run; edges then wait.
// - In edge limit one-shot, start and reset edges raise the drive; width match drops it.
// - Level limit one-shot holds the count at zero at the reset level and counts once released.
// - Level one-shot clears run on period match and needs a new edge after rearming.
// - In level one-shot the drive rises on the starting edge, falls at width match, not at wrap.
// - With the sync bit set the timer freezes in sleep and keeps count and period.
// - With the sync bit clear the timer keeps counting in sleep.
// - In free-running mode the count wraps to zero on the clock after it equals the period.
// - The postscaled pulse lasts one system clock when the postscaler reaches its setting.
// - A five-bit mode field picks the mode; a separate register picks the reset source.
module hlot_timer #(
   parameter int SRC_COUNT = 16
) (
   input wire logic sysClk, // system clock
   input wire logic rstN, // synchronous reset, active low
   input wire logic [SRC_COUNT-1:0] extResetSources, // candidate external reset signals
   input wire logic sleepActive, // processor is in sleep
   input wire logic [7:0] awaddr, // axi write address
   input wire logic awvalid, // axi write address valid
   output logic awready, // axi write address ready
   input wire logic [31:0] wdata, // axi write data
   input wire logic [3:0] wstrb, // axi write strobes
   input wire logic wvalid, // axi write data valid
   output logic wready, // axi write data ready
   output logic [1:0] bresp, // axi write response
   output logic bvalid, // axi write response valid
   input wire logic bready, // axi write response ready
   input wire logic [7:0] araddr, // axi read address
   input wire logic arvalid, // axi read address valid
   output logic arready, // axi read address ready
   output logic [31:0] rdata, // axi read data
   output logic [1:0] rresp, // axi read response
   output logic rvalid, // axi read valid
   input wire logic rready, // axi read ready
   output logic [7:0] countValue, // count to the pwm comparator
   output logic periodMatchOut, // count equals period
   output logic postscaledPulse, // one-clock postscaled pulse
   output logic pwmDrive, // pwm drive level
   output logic irq // interrupt, high while unmasked status set
);
   // the source select field is four bits wide, so more than 16 lines cannot be reached
   if (SRC_COUNT < 1 || SRC_COUNT > 16) begin : g_bad_src_count
      $error("SRC_COUNT must be 1..16");
   end

   hlot_pkg::hlot_state_t s_reg;
   hlot_pkg::hlot_state_t s_next;

   // ==========================================================
   // derived combinational terms
   logic [4:0] mode;
   logic extSig;
   logic rise;
   logic fall;
   logic edgeSel;
   logic levelReset;
   logic tick;
   logic match;
   logic oneShot;
   logic edgeOs;
   logic edgeHl;
   logic levelHl;
   logic [6:0] preLimit;
   logic run;
   logic armedNew;
   logic wrFire;
   logic rdFire;
   logic [7:0] wByte;
   logic [7:0] rByte;
   logic rdOk;
   logic wrOk;

   always_comb begin
      mode = s_reg.limit[hlot_pkg::LIM_MODE_LSB +: 5];
      // five-bit compare: a 4-bit cast of 16 would wrap to zero and mute every source
      extSig = ({1'b0, s_reg.rstSel[3:0]} < 5'(SRC_COUNT))
         ? extResetSources[s_reg.rstSel[3:0]] : 1'b0;
      rise = extSig & ~s_reg.extPrev;
      fall = ~extSig & s_reg.extPrev;
      edgeOs = (mode == hlot_pkg::MODE_OS_RISE) || (mode == hlot_pkg::MODE_OS_FALL)
         || (mode == hlot_pkg::MODE_OS_ANY);
      edgeHl = (mode == hlot_pkg::MODE_HLE_RISE) || (mode == hlot_pkg::MODE_HLE_FALL);
      levelHl = (mode == hlot_pkg::MODE_HLL_HIGH) || (mode == hlot_pkg::MODE_HLL_LOW);
      oneShot = edgeOs || edgeHl || levelHl;
      unique case (mode)
         hlot_pkg::MODE_OS_RISE, hlot_pkg::MODE_HLE_RISE: edgeSel = rise;
         hlot_pkg::MODE_OS_FALL, hlot_pkg::MODE_HLE_FALL: edgeSel = fall;
         hlot_pkg::MODE_OS_ANY: edgeSel = rise | fall;
         hlot_pkg::MODE_HLL_HIGH: edgeSel = fall; // level released
         hlot_pkg::MODE_HLL_LOW: edgeSel = rise;
         default: edgeSel = 1'b0;
      endcase
      levelReset = (mode == hlot_pkg::MODE_HLL_HIGH) ? extSig : ~extSig;
      // prescale 1:2^n; sleep with sync set freezes the prescaler and stops every tick
      preLimit = 7'((8'h01 << s_reg.control[hlot_pkg::CTRL_PRE_LSB +: 3]) - 8'h01);
      tick = (s_reg.preCnt >= preLimit)
         && !(sleepActive && s_reg.limit[hlot_pkg::LIM_PRESCALER_SYNC]);
      run = s_reg.control[hlot_pkg::CTRL_RUN];
      armedNew = run && !s_reg.runPrev;
      match = (s_reg.count == s_reg.period);
      wrFire = s_reg.awDone && s_reg.wDone && !s_reg.bValid;
      rdFire = arvalid && !s_reg.rValid;
   end

   // ==========================================================
   // register read mux
   always_comb begin
      rdOk = 1'b1;
      unique case (araddr)
         hlot_pkg::ADDR_PERIOD: rByte = s_reg.period;
         hlot_pkg::ADDR_COUNT: rByte = s_reg.count;
         hlot_pkg::ADDR_CONTROL: rByte = s_reg.control;
         hlot_pkg::ADDR_CLKSEL: rByte = s_reg.clkSel;
         hlot_pkg::ADDR_RSTSEL: rByte = s_reg.rstSel;
         hlot_pkg::ADDR_LIMIT: rByte = s_reg.limit;
         hlot_pkg::ADDR_PULSE: rByte = s_reg.pulse;
         hlot_pkg::ADDR_IRQ_STAT: rByte = {5'h00, s_reg.irqStat};
         hlot_pkg::ADDR_IRQ_MASK: rByte = {5'h00, s_reg.irqMask};
         default: begin
            rByte = hlot_pkg::ZERO8;
            rdOk = 1'b0;
         end
      endcase
      wByte = s_reg.wStrb[0] ? s_reg.wData[7:0] : hlot_pkg::ZERO8;
      wrOk = (s_reg.awAddr <= hlot_pkg::ADDR_IRQ_MASK) && (s_reg.awAddr[1:0] == 2'h0);
   end

   // ==========================================================
   // next-state logic
   always_comb begin
      logic [2:0] events;
      logic restartDue;
      events = 3'h0;
      restartDue = 1'b0;
      s_next = s_reg;
      s_next.extPrev = extSig;
      s_next.runPrev = run;
      s_next.postPulse = 1'b0;
      s_next.preCnt = tick ? 7'h00 : 7'(s_reg.preCnt + 7'h01);
      if (sleepActive && s_reg.limit[hlot_pkg::LIM_PRESCALER_SYNC]) begin
         s_next.preCnt = s_reg.preCnt;
      end

      // timer engine
      if (!run) begin
         s_next.phase = hlot_pkg::HLOT_IDLE;
         s_next.restartCnt = 2'h0;
      end else if (!oneShot) begin
         s_next.phase = hlot_pkg::HLOT_CNT;
      end else if (armedNew || s_reg.phase == hlot_pkg::HLOT_IDLE) begin
         s_next.phase = hlot_pkg::HLOT_WAIT; // fresh edge needed after arming
      end
      if (run && oneShot && s_reg.phase == hlot_pkg::HLOT_WAIT && edgeSel) begin
         s_next.phase = hlot_pkg::HLOT_CNT;
         s_next.pwmDrive = 1'b1;
      end else if (run && edgeHl && s_reg.phase == hlot_pkg::HLOT_CNT && edgeSel) begin
         s_next.count = hlot_pkg::ZERO8;
         s_next.restartCnt = hlot_pkg::RESTART_CLKS;
         s_next.pwmDrive = 1'b1;
         events[hlot_pkg::IRQ_EXTRST] = 1'b1;
      end else if (run && levelHl && s_reg.phase == hlot_pkg::HLOT_CNT && levelReset) begin
         s_next.count = hlot_pkg::ZERO8;
      end else if (run && s_reg.phase == hlot_pkg::HLOT_CNT && tick) begin
         if (s_reg.restartCnt != 2'h0) begin
            s_next.restartCnt = 2'(s_reg.restartCnt - 2'h1);
            restartDue = 1'b1;
         end else if (match) begin
            s_next.count = hlot_pkg::ZERO8;
            events[hlot_pkg::IRQ_MATCH] = 1'b1;
            if (s_reg.postCnt == s_reg.control[hlot_pkg::CTRL_POST_LSB +: 4]) begin
               s_next.postCnt = 4'h0;
               s_next.postPulse = 1'b1;
               events[hlot_pkg::IRQ_POST] = 1'b1;
            end else begin
               s_next.postCnt = 4'(s_reg.postCnt + 4'h1);
            end
            if (oneShot) begin
               s_next.control[hlot_pkg::CTRL_RUN] = 1'b0;
               s_next.phase = hlot_pkg::HLOT_IDLE;
            end
         end else begin
            s_next.count = 8'(s_reg.count + 8'h01);
         end
         if (!restartDue && s_reg.count == s_reg.pulse && oneShot) begin
            s_next.pwmDrive = 1'b0;
         end
      end
      s_next.matchOut = match && s_reg.phase == hlot_pkg::HLOT_CNT;

      // axi write channels
      if (awvalid && !s_reg.awDone) begin
         s_next.awDone = 1'b1;
         s_next.awAddr = awaddr;
      end
      if (wvalid && !s_reg.wDone) begin
         s_next.wDone = 1'b1;
         s_next.wData = wdata;
         s_next.wStrb = wstrb;
      end
      if (wrFire) begin
         s_next.awDone = 1'b0;
         s_next.wDone = 1'b0;
         s_next.bValid = 1'b1;
         s_next.bResp = wrOk ? hlot_pkg::RESP_OKAY : hlot_pkg::RESP_SLVERR;
         if (s_reg.wStrb[0]) begin
            unique case (s_reg.awAddr)
               hlot_pkg::ADDR_PERIOD: s_next.period = wByte;
               hlot_pkg::ADDR_COUNT: s_next.count = wByte;
               hlot_pkg::ADDR_CONTROL: s_next.control = wByte;
               hlot_pkg::ADDR_CLKSEL: s_next.clkSel = {5'h00, wByte[2:0]};
               hlot_pkg::ADDR_RSTSEL: s_next.rstSel = {4'h0, wByte[3:0]};
               hlot_pkg::ADDR_LIMIT: s_next.limit = wByte;
               hlot_pkg::ADDR_PULSE: s_next.pulse = wByte;
               hlot_pkg::ADDR_IRQ_MASK: s_next.irqMask = wByte[2:0];
               default: s_next.period = s_reg.period;
            endcase
         end
      end
      if (s_reg.bValid && bready) begin
         s_next.bValid = 1'b0;
      end

      // axi read; a status read clears, but fresh events win
      if (rdFire) begin
         s_next.rValid = 1'b1;
         s_next.rData = {24'h000000, rByte};
         s_next.rResp = rdOk ? hlot_pkg::RESP_OKAY : hlot_pkg::RESP_SLVERR;
         if (araddr == hlot_pkg::ADDR_IRQ_STAT) begin
            s_next.irqStat = 3'h0;
         end
      end
      if (s_reg.rValid && rready) begin
         s_next.rValid = 1'b0;
      end
      s_next.irqStat = s_next.irqStat | events;
      s_next.irq = |(s_next.irqStat & s_reg.irqMask);
   end

   // ==========================================================
   // state register
   always_ff @(posedge sysClk) begin
      if (!rstN) begin
         s_reg <= '0;
         s_reg.period <= hlot_pkg::PERIOD_RST;
         s_reg.phase <= hlot_pkg::HLOT_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign awready = !s_reg.awDone;
   assign wready = !s_reg.wDone;
   assign bvalid = s_reg.bValid;
   assign bresp = s_reg.bResp;
   assign arready = !s_reg.rValid;
   assign rvalid = s_reg.rValid;
   assign rdata = s_reg.rData;
   assign rresp = s_reg.rResp;
   assign countValue = s_reg.count;
   assign periodMatchOut = s_reg.matchOut;
   assign postscaledPulse = s_reg.postPulse;
   assign pwmDrive = s_reg.pwmDrive;
   assign irq = s_reg.irq;
endmodule

`default_nettype wire

//--- shared/hlot_pkg.sv
// package of constants and types for the hardware-limit one-shot timer
package hlot_pkg;
   // ==========================================================
   // register byte addresses
   localparam logic [7:0] ADDR_PERIOD = 8'h00;
   localparam logic [7:0] ADDR_COUNT = 8'h04;
   localparam logic [7:0] ADDR_CONTROL = 8'h08;
   localparam logic [7:0] ADDR_CLKSEL = 8'h0c;
   localparam logic [7:0] ADDR_RSTSEL = 8'h10;
   localparam logic [7:0] ADDR_LIMIT = 8'h14;
   localparam logic [7:0] ADDR_PULSE = 8'h18;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
   // ==========================================================
   // field positions
   localparam int CTRL_RUN = 7;
   localparam int CTRL_PRE_LSB = 4;
   localparam int CTRL_POST_LSB = 0;
   localparam int LIM_PRESCALER_SYNC = 7;
   localparam int LIM_MODE_LSB = 0;
   localparam int IRQ_MATCH = 0;
   localparam int IRQ_POST = 1;
   localparam int IRQ_EXTRST = 2;
   // ==========================================================
   // reset values
   localparam logic [7:0] PERIOD_RST = 8'hff;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // timing: restart delay after a hardware-limit reset edge, in timer clocks
   localparam logic [1:0] RESTART_CLKS = 2'h2;
   // ==========================================================
   // mode codes
   localparam logic [4:0] MODE_FREE = 5'h00;
   localparam logic [4:0] MODE_OS_RISE = 5'h09;
   localparam logic [4:0] MODE_OS_FALL = 5'h0a;
   localparam logic [4:0] MODE_OS_ANY = 5'h0b;
   localparam logic [4:0] MODE_HLE_RISE = 5'h0c;
   localparam logic [4:0] MODE_HLE_FALL = 5'h0d;
   localparam logic [4:0] MODE_HLL_HIGH = 5'h0e;
   localparam logic [4:0] MODE_HLL_LOW = 5'h0f;

   typedef enum logic [2:0] {
      HLOT_IDLE = 3'b001,
      HLOT_WAIT = 3'b010,
      HLOT_CNT = 3'b100
   } hlot_phase_t;

   typedef struct packed {
      logic [7:0] period;
      logic [7:0] count;
      logic [7:0] control;
      logic [7:0] clkSel;
      logic [7:0] rstSel;
      logic [7:0] limit;
      logic [7:0] pulse;
      logic [2:0] irqStat;
      logic [2:0] irqMask;
      hlot_phase_t phase;
      logic [1:0] restartCnt;
      logic [6:0] preCnt;
      logic [3:0] postCnt;
      logic extPrev;
      logic runPrev;
      logic pwmDrive;
      logic matchOut;
      logic postPulse;
      logic irq;
      logic awDone;
      logic wDone;
      logic [7:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } hlot_state_t;
endpackage

//--- test/hlot_ext_model.sv
// far-side trigger source: selected line follows the bench, the others chatter
`timescale 1ns/1ps
`default_nettype none
module hlot_ext_model #(
   parameter int SEL = 3
) (
   input wire logic clk, // timer clock
   input wire logic rstN, // sync reset, active low
   input wire logic lvl, // level wanted on the selected line
   output logic [15:0] srcs // candidate trigger lines
);
   // ==========================================================
   // unselected lines toggle, so a wrong source pick starts the timer early
   logic [15:0] chatterReg;
   always_ff @(posedge clk) begin
      if (!rstN) begin
         chatterReg <= 16'h0000;
      end else begin
         chatterReg <= ~chatterReg;
      end
   end
   always_comb begin
      srcs = chatterReg;
      srcs[SEL] = lvl;
   end
endmodule
`default_nettype wire

//--- test/hlot_timer_chk.sv
// concurrent checks on the timer's bus and timer outputs
`timescale 1ns/1ps
`default_nettype none
module hlot_timer_chk (
   input wire logic sysClk, // clock
   input wire logic rstN, // sync reset, active low
   input wire logic awvalid, // write address valid
   input wire logic awready, // write address ready
   input wire logic wvalid, // write data valid
   input wire logic wready, // write data ready
   input wire logic bvalid, // write response valid
   input wire logic bready, // write response ready
   input wire logic arvalid, // read address valid
   input wire logic arready, // read address ready
   input wire logic rvalid, // read valid
   input wire logic rready, // read ready
   input wire logic [31:0] rdata, // read data
   input wire logic [7:0] countValue, // count
   input wire logic periodMatchOut, // period match
   input wire logic postscaledPulse // postscaled pulse
);
   // ==========================================================
   // bus and timer relations
   default clocking cb @(posedge sysClk);
   endclocking
   default disable iff (!rstN);
   chk_reset_outputs: assert property (disable iff (1'h0)
      !rstN |=> awready && arready && !bvalid && !rvalid && countValue == 8'h00)
      else $error("outputs not cleared by reset");
   chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("write response late");
   chk_aw_closes: assert property (awvalid && awready |=> !awready)
      else $error("address taken twice");
   chk_b_retire: assert property (bvalid && bready |=> !bvalid)
      else $error("write response repeated");
   chk_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read response late");
   chk_r_retire: assert property (rvalid && rready |=> !rvalid)
      else $error("read response repeated");
   chk_ar_blocked: assert property (rvalid |-> !arready && rdata[31:8] == 24'h000000)
      else $error("read overlap or wide data");
   chk_match_wraps: assert property (periodMatchOut |-> countValue == 8'h00)
      else $error("count not cleared at match");
   chk_post_single: assert property (postscaledPulse |=> !postscaledPulse)
      else $error("postscaled pulse too long");
endmodule
bind hlot_timer hlot_timer_chk chk_i (.*);
`default_nettype wire

//--- test/hlot_timer_tb.sv
// self-checking bench for the hardware-limit one-shot timer
`timescale 1ns/1ps
`default_nettype none
module hlot_timer_tb;
   logic sysClk = 1'h0, rstN = 1'h0, sleepActive = 1'h0, extLvl = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic [15:0] extResetSources;
   logic awready, wready, bvalid, arready, rvalid, periodMatchOut, postscaledPulse, pwmDrive, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] countValue;
   int errTotal = 0;
   int checksDone = 0;
   hlot_timer dut (.*);
   hlot_ext_model src (.clk(sysClk), .rstN, .lvl(extLvl), .srcs(extResetSources));
   always #4 sysClk = ~sysClk;
   // ==========================================================
   // checking and bus tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errTotal++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic reportAndStop();
      if (errTotal == 0 && checksDone > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic giveUp(input int n);
      if (n >= 100) begin
         errTotal++;
         reportAndStop();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
         input logic [1:0] er = hlot_pkg::RESP_OKAY);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge sysClk);
         n++;
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
      end while (bvalid !== 1'h1 && n < 100);
      giveUp(n);
      bready <= 1'h0;
      chk("bresp", {30'h0, bresp}, {30'h0, er});
      @(posedge sysClk);
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e,
         input logic [1:0] er = hlot_pkg::RESP_OKAY);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge sysClk);
         n++;
         if (arready === 1'h1) arvalid <= 1'h0;
      end while (rvalid !== 1'h1 && n < 100);
      giveUp(n);
      chk("rdata", rdata, e);
      chk("rresp", {30'h0, rresp}, {30'h0, er});
      rready <= 1'h0;
      @(posedge sysClk);
   endtask
   task automatic waitCnt(input logic [7:0] v);
      int n;
      n = 0;
      do begin
         @(posedge sysClk);
         n++;
      end while (countValue !== v && n < 100);
      giveUp(n);
   endtask
   // ==========================================================
   // scenarios
   initial begin
      logic [7:0] md [7];
      logic [6:0] idle;
      logic [7:0] held;
      int np;
      int nm;
      md = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f};
      idle = 7'h32; // starting level per mode, bit i for md[i]
      np = 0;
      nm = 0;
      repeat (20) @(posedge sysClk);
      rstN <= 1'h1;
      @(posedge sysClk);
      rdChk(hlot_pkg::ADDR_PERIOD, 32'h000000ff);
      rdChk(8'h24, 32'h0, hlot_pkg::RESP_SLVERR);
      wr(8'h26, 8'h00, hlot_pkg::RESP_SLVERR);
      wr(hlot_pkg::ADDR_RSTSEL, 8'h03);
      wr(hlot_pkg::ADDR_PERIOD, 8'h05);
      wr(hlot_pkg::ADDR_IRQ_MASK, 8'h01);
      wr(hlot_pkg::ADDR_CONTROL, 8'h81);
      waitCnt(8'h05);
      @(posedge sysClk);
      chk("wrap", {24'h0, countValue}, 32'h0);
      repeat (24) begin
         @(posedge sysClk);
         if (postscaledPulse === 1'h1) np++;
         if (periodMatchOut === 1'h1) nm++;
      end
      chk("matches", nm, 4);
      chk("pulses", np, 2);
      chk("irq up", irq, 1'h1);
      wr(hlot_pkg::ADDR_CONTROL, 8'h00);
      wr(hlot_pkg::ADDR_IRQ_MASK, 8'h00);
      @(posedge sysClk);
      chk("irq masked", irq, 1'h0);
      rdChk(hlot_pkg::ADDR_IRQ_STAT, 32'h3);
      rdChk(hlot_pkg::ADDR_IRQ_STAT, 32'h0);
      wr(hlot_pkg::ADDR_PERIOD, 8'hff);
      wr(hlot_pkg::ADDR_CONTROL, 8'h80);
      sleepActive <= 1'h1;
      @(posedge sysClk);
      held = countValue;
      repeat (5) @(posedge sysClk);
      chk("sleep runs", countValue === held, 1'h0);
      sleepActive <= 1'h0;
      wr(hlot_pkg::ADDR_LIMIT, 8'h80);
      sleepActive <= 1'h1;
      repeat (2) @(posedge sysClk);
      held = countValue;
      repeat (9) @(posedge sysClk);
      chk("sleep holds", countValue, held);
      sleepActive <= 1'h0;
      rdChk(hlot_pkg::ADDR_PERIOD, 32'h000000ff);
      wr(hlot_pkg::ADDR_CONTROL, 8'h00);
      wr(hlot_pkg::ADDR_PERIOD, 8'h05);
      wr(hlot_pkg::ADDR_PULSE, 8'h03);
      for (int i = 0; i < 7; i++) begin
         extLvl <= idle[i];
         wr(hlot_pkg::ADDR_COUNT, 8'h00);
         wr(hlot_pkg::ADDR_LIMIT, md[i]);
         rdChk(hlot_pkg::ADDR_LIMIT, {24'h0, md[i]});
         wr(hlot_pkg::ADDR_CONTROL, 8'h80);
         repeat (6) @(posedge sysClk);
         chk("armed idle", countValue, 32'h0);
         extLvl <= ~idle[i];
         waitCnt(8'h01);
         chk("drive on", pwmDrive, 1'h1);
         if (i == 3 || i == 4) begin
            waitCnt(8'h02);
            extLvl <= idle[i];
            @(posedge sysClk);
            extLvl <= ~idle[i];
            waitCnt(8'h00);
            waitCnt(8'h01);
            chk("drive again", pwmDrive, 1'h1);
         end
         waitCnt(8'h05);
         repeat (3) @(posedge sysClk);
         chk("drive off", pwmDrive, 1'h0);
         rdChk(hlot_pkg::ADDR_CONTROL, 32'h0);
         extLvl <= idle[i];
         repeat (4) @(posedge sysClk);
         chk("edge ignored", countValue, 32'h0);
      end
      // software stop in mid-count: rearming alone must not resume
      wr(hlot_pkg::ADDR_PERIOD, 8'h20);
      wr(hlot_pkg::ADDR_LIMIT, {3'h0, hlot_pkg::MODE_OS_RISE});
      extLvl <= 1'h0;
      wr(hlot_pkg::ADDR_CONTROL, 8'h80);
      repeat (3) @(posedge sysClk);
      extLvl <= 1'h1;
      waitCnt(8'h02);
      wr(hlot_pkg::ADDR_CONTROL, 8'h00);
      held = countValue;
      wr(hlot_pkg::ADDR_CONTROL, 8'h80);
      repeat (6) @(posedge sysClk);
      chk("no resume", countValue, held);
      extLvl <= 1'h0;
      repeat (2) @(posedge sysClk);
      extLvl <= 1'h1;
      waitCnt(8'(held + 8'h01));
      reportAndStop();
   end
endmodule
`default_nettype wire
